// ---- logic/dgs_diag_map.vh ----
`ifndef DGS_DIAG_MAP_VH
`define DGS_DIAG_MAP_VH

// Byte addresses on the serial register port
`define DGS_ADDR_MISC_LO     7'h34
`define DGS_ADDR_MISC_HI     7'h35
`define DGS_ADDR_DIAG_LO     7'h3C
`define DGS_ADDR_DIAG_HI     7'h3D

// misc_control layout
`define DGS_MISC_RESET       16'h0006
`define DGS_MISC_KEEP_MASK   16'h03C7
`define DGS_MISC_MEMTEST     11
`define DGS_MISC_SELFTEST    10
`define DGS_MISC_STIM_NEG    9
`define DGS_MISC_STIM_POS    8

// diagnostic_error_status layout
`define DGS_DIAG_RESET       16'h0000
`define DGS_DIAG_ZFAIL       15
`define DGS_DIAG_YFAIL       14
`define DGS_DIAG_XFAIL       13
`define DGS_DIAG_GFAIL       10
`define DGS_DIAG_ALM2        9
`define DGS_DIAG_ALM1        8
`define DGS_DIAG_FLASH       6
`define DGS_DIAG_STERR       5
`define DGS_DIAG_OVR         4
`define DGS_DIAG_SPI         3
`define DGS_DIAG_FUPD        2
`define DGS_DIAG_SUPHI       1
`define DGS_DIAG_SUPLO       0

// Timing and sizes
`define DGS_ST_SETTLE        8
`define DGS_FLASH_DEPTH      256
`define DGS_FLASH_AW         8

`endif

// ---- logic/dgs_selftest_seq.v ----
`include "dgs_diag_map.vh"

module dgs_selftest_seq #(
  parameter SETTLE = `DGS_ST_SETTLE,
  parameter NSENS  = 4
) (
  input  wire             clk_sys,
  input  wire             srst,
  input  wire             sampleTick,
  input  wire             start,
  input  wire [NSENS-1:0] respOk,
  output reg              stimPos,
  output reg              stimNeg,
  output reg              busy,
  output reg              done,
  output reg  [NSENS-1:0] fail
);

  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_POS  = 2'd1;
  localparam [1:0] S_NEG  = 2'd2;
  localparam [1:0] S_FIN  = 2'd3;

  reg [1:0]       state;
  reg [7:0]       cnt;
  reg [NSENS-1:0] posOk;

  localparam [31:0] SETTLE_M1 = SETTLE - 1;

  wire settled = sampleTick && (cnt == SETTLE_M1[7:0]);

  always @(posedge clk_sys) begin
    if (srst) begin
      state   <= S_IDLE;
      cnt     <= 8'h00;
      posOk   <= {NSENS{1'b0}};
      stimPos <= 1'b0;
      stimNeg <= 1'b0;
      busy    <= 1'b0;
      done    <= 1'b0;
      fail    <= {NSENS{1'b0}};
    end else begin
      done <= 1'b0;
      if (sampleTick && !settled)
        cnt <= cnt + 8'h01;
      case (state)
        S_IDLE: begin
          cnt <= 8'h00;
          if (start) begin
            state   <= S_POS;
            busy    <= 1'b1;
            stimPos <= 1'b1;
          end
        end
        S_POS: begin
          if (settled) begin
            posOk   <= respOk;
            cnt     <= 8'h00;
            stimPos <= 1'b0;
            stimNeg <= 1'b1;
            state   <= S_NEG;
          end
        end
        S_NEG: begin
          if (settled) begin
            // A sensor passes only if both polarities answered in range
            fail    <= ~(posOk & respOk);
            stimNeg <= 1'b0;
            state   <= S_FIN;
          end
        end
        S_FIN: begin
          done  <= 1'b1;
          busy  <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

// ---- logic/dgs_diag_status.v ----
// Functional notes
// - Self-test start stimulates every sensor, judges each, records per-sensor failures.
// - Self-test enable bit returns to 0 by itself when the routine ends.
// - Two manual stimulus bits hold stimulus applied while set.
// - Bit 9 gives negative stimulus, bit 8 positive; active at 1.
// - Memory test bit starts a flash checksum and pass/fail comparison.
// - Memory test bit clears itself when the checksum finishes.
// - Flash checksum failure shows as 1 in status bit 6.
// - Every status register read clears all error flags but the two supply flags in bits 1 and 0.
// - A persisting error sets its flag again on the next sample cycle.
// - Supply flags clear themselves when the supply returns inside range.
// - Supply-high flag follows monitor at or above upper limit.
// - Supply-low flag follows monitor at or below lower limit.
// - Z, Y, X accel failures in bits 15..13, gyro failure in bit 10.
// - Bit 5 summarises any self-test error.
// - Alarm 2 in bit 9, alarm 1 in bit 8, 1 while active.
// - Overrange bit 4, serial failure bit 3, flash update failure bit 2.
`include "dgs_diag_map.vh"

module dgs_diag_status #(
  parameter ST_SETTLE   = `DGS_ST_SETTLE,
  parameter FLASH_DEPTH = `DGS_FLASH_DEPTH,
  parameter FLASH_AW    = `DGS_FLASH_AW
) (
  input  wire                clk_sys,
  input  wire                srst,
  input  wire                sampleTick,
  input  wire                wrEn,
  input  wire [6:0]          wrAddr,
  input  wire [7:0]          wrData,
  input  wire                rdEn,
  input  wire [6:0]          rdAddr,
  output reg  [15:0]         rdData,
  input  wire [3:0]          respOk,
  output reg                 stimPos,
  output reg                 stimNeg,
  output reg  [FLASH_AW-1:0] flashAddr,
  output reg                 flashRdEn,
  input  wire [15:0]         flashData,
  input  wire                supplyHigh,
  input  wire                supplyLow,
  input  wire                alarm1,
  input  wire                alarm2,
  input  wire                overrange,
  input  wire                serialFail,
  input  wire                flashUpdFail,
  output reg  [7:0]          miscConfig
);

  localparam [1:0] M_IDLE = 2'd0;
  localparam [1:0] M_RUN  = 2'd1;
  localparam [1:0] M_WAIT = 2'd2;

  localparam [31:0]         FLASH_LAST_W = FLASH_DEPTH - 1;
  localparam [FLASH_AW-1:0] FLASH_LAST   = FLASH_LAST_W[FLASH_AW-1:0];
  localparam [15:0]         KEEP_MASK    = `DGS_MISC_KEEP_MASK;
  localparam [6:0]          ADDR_DIAG    = `DGS_ADDR_DIAG_LO;
  localparam [6:0]          ADDR_MISC    = `DGS_ADDR_MISC_LO;

  reg  [15:0]         misc;
  reg  [15:0]         diag;
  reg  [15:0]         next_diag;
  reg  [15:0]         cond;
  reg  [1:0]          mState;
  reg  [15:0]         sum;
  reg                 pend;
  reg                 pendLast;
  reg                 memDone;
  reg                 flashBad;
  reg                 stStart;

  wire                stBusy;
  wire                stDone;
  wire                seqPos;
  wire                seqNeg;
  wire [3:0]          stFail;

  wire wrMiscLo = wrEn && (wrAddr == `DGS_ADDR_MISC_LO);
  wire wrMiscHi = wrEn && (wrAddr == `DGS_ADDR_MISC_HI);
  wire rdDiag   = rdEn && (rdAddr[6:1] == ADDR_DIAG[6:1]);
  wire rdMisc   = rdEn && (rdAddr[6:1] == ADDR_MISC[6:1]);

  wire stReq  = wrMiscHi && wrData[`DGS_MISC_SELFTEST - 8] && !stBusy && !stStart;
  wire memReq = wrMiscHi && wrData[`DGS_MISC_MEMTEST - 8] && (mState == M_IDLE);
  wire memBusy = (mState != M_IDLE);

  wire [15:0] miscView = (misc & `DGS_MISC_KEEP_MASK)
                       | ({15'h0000, memBusy} << `DGS_MISC_MEMTEST)
                       | ({15'h0000, stBusy | stStart} << `DGS_MISC_SELFTEST);

  dgs_selftest_seq #(
    .SETTLE (ST_SETTLE),
    .NSENS  (4)
  ) u_seq (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .sampleTick (sampleTick),
    .start      (stStart),
    .respOk     (respOk),
    .stimPos    (seqPos),
    .stimNeg    (seqNeg),
    .busy       (stBusy),
    .done       (stDone),
    .fail       (stFail)
  );

  // Control register and self-test launch
  always @(posedge clk_sys) begin
    if (srst) begin
      misc       <= `DGS_MISC_RESET;
      stStart    <= 1'b0;
      miscConfig <= 8'h00;
      stimPos    <= 1'b0;
      stimNeg    <= 1'b0;
    end else begin
      stStart <= stReq;
      if (wrMiscLo)
        misc[7:0] <= wrData & KEEP_MASK[7:0];
      if (wrMiscHi)
        misc[15:8] <= wrData & KEEP_MASK[15:8];
      miscConfig <= misc[7:0];
      // Manual and automatic stimulus share the sensor drive lines
      stimPos <= misc[`DGS_MISC_STIM_POS] | seqPos;
      stimNeg <= misc[`DGS_MISC_STIM_NEG] | seqNeg;
    end
  end

  // Flash checksum: sum of all words but the last must equal the last
  always @(posedge clk_sys) begin
    if (srst) begin
      mState    <= M_IDLE;
      flashAddr <= {FLASH_AW{1'b0}};
      flashRdEn <= 1'b0;
      sum       <= 16'h0000;
      pend      <= 1'b0;
      pendLast  <= 1'b0;
      memDone   <= 1'b0;
      flashBad  <= 1'b0;
    end else begin
      memDone  <= 1'b0;
      pend     <= flashRdEn;
      pendLast <= flashRdEn && (flashAddr == FLASH_LAST);
      case (mState)
        M_IDLE: begin
          if (memReq) begin
            flashAddr <= {FLASH_AW{1'b0}};
            flashRdEn <= 1'b1;
            sum       <= 16'h0000;
            mState    <= M_RUN;
          end
        end
        M_RUN: begin
          if (flashAddr == FLASH_LAST) begin
            flashRdEn <= 1'b0;
            mState    <= M_WAIT;
          end else begin
            flashAddr <= flashAddr + {{(FLASH_AW-1){1'b0}}, 1'b1};
          end
          if (pend)
            sum <= sum + flashData;
        end
        M_WAIT: begin
          if (pend && pendLast) begin
            flashBad <= (sum != flashData);
            memDone  <= 1'b1;
            mState   <= M_IDLE;
          end else if (pend) begin
            sum <= sum + flashData;
          end
        end
        default: mState <= M_IDLE;
      endcase
    end
  end

  // Conditions that re-arm the sticky flags on each sample cycle
  always @* begin
    cond                  = 16'h0000;
    cond[`DGS_DIAG_ZFAIL] = stFail[3];
    cond[`DGS_DIAG_YFAIL] = stFail[2];
    cond[`DGS_DIAG_XFAIL] = stFail[1];
    cond[`DGS_DIAG_GFAIL] = stFail[0];
    cond[`DGS_DIAG_ALM2]  = alarm2;
    cond[`DGS_DIAG_ALM1]  = alarm1;
    cond[`DGS_DIAG_FLASH] = flashBad;
    cond[`DGS_DIAG_STERR] = |stFail;
    cond[`DGS_DIAG_OVR]   = overrange;
    cond[`DGS_DIAG_SPI]   = serialFail;
    cond[`DGS_DIAG_FUPD]  = flashUpdFail;
  end

  always @* begin
    next_diag = diag;
    if (rdDiag)
      next_diag = 16'h0000;
    // Setting after clearing lets a same-cycle event win over the read
    if (sampleTick)
      next_diag = next_diag | cond;
    if (stDone) begin
      next_diag[`DGS_DIAG_ZFAIL] = next_diag[`DGS_DIAG_ZFAIL] | stFail[3];
      next_diag[`DGS_DIAG_YFAIL] = next_diag[`DGS_DIAG_YFAIL] | stFail[2];
      next_diag[`DGS_DIAG_XFAIL] = next_diag[`DGS_DIAG_XFAIL] | stFail[1];
      next_diag[`DGS_DIAG_GFAIL] = next_diag[`DGS_DIAG_GFAIL] | stFail[0];
      next_diag[`DGS_DIAG_STERR] = next_diag[`DGS_DIAG_STERR] | (|stFail);
    end
    // The verdict is latched with the done pulse; the flash bus has moved on by now
    if (memDone)
      next_diag[`DGS_DIAG_FLASH] = next_diag[`DGS_DIAG_FLASH] | flashBad;
    next_diag[`DGS_DIAG_SUPHI] = supplyHigh;
    next_diag[`DGS_DIAG_SUPLO] = supplyLow;
    next_diag[12:11] = 2'b00;
    next_diag[7]     = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      diag   <= `DGS_DIAG_RESET;
      rdData <= 16'h0000;
    end else begin
      diag <= next_diag;
      if (rdDiag)
        rdData <= diag;
      else if (rdMisc)
        rdData <= miscView;
      else if (rdEn)
        rdData <= 16'h0000;
    end
  end

endmodule

// ---- testbench/dgs_diag_status_assertions.sv ----
module dgs_diag_chk #(
  parameter FLASH_DEPTH = 256,
  parameter FLASH_AW    = 8
) (
  input wire                clk_sys,
  input wire                srst,
  input wire                sampleTick,
  input wire                wrEn,
  input wire [6:0]          wrAddr,
  input wire [7:0]          wrData,
  input wire                rdEn,
  input wire [6:0]          rdAddr,
  input wire [15:0]         rdData,
  input wire                stimPos,
  input wire                stimNeg,
  input wire [FLASH_AW-1:0] flashAddr,
  input wire                flashRdEn,
  input wire                supplyHigh,
  input wire                supplyLow,
  input wire                alarm1,
  input wire                alarm2,
  input wire                overrange
);
  timeunit 1ns;
  timeprecision 1ps;
  wire rdDiag = rdEn && rdAddr[6:1] == 6'h1E;
  wire wHi    = wrEn && wrAddr == 7'h35;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_unused; rdDiag |=> rdData[12:11] == 2'b00 && !rdData[7]; endproperty
  a_unused: assert property (p_unused) else $error("unused status bit set");
  property p_suphi; rdDiag && $past(supplyHigh) |=> rdData[1]; endproperty
  a_suphi: assert property (p_suphi) else $error("supply high flag missing");
  property p_suplo; rdDiag && !$past(supplyLow) |=> !rdData[0]; endproperty
  a_suplo: assert property (p_suplo) else $error("supply low flag stuck");
  property p_alarm;
    sampleTick ##1 rdDiag |=>
      (rdData[9:8] & {$past(alarm2, 2), $past(alarm1, 2)}) == {$past(alarm2, 2), $past(alarm1, 2)};
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag missing");
  property p_ovr; sampleTick ##1 rdDiag |=> rdData[4] || !$past(overrange, 2); endproperty
  a_ovr: assert property (p_ovr) else $error("overrange flag missing");
  property p_clear;
    (rdDiag && !sampleTick) ##1 (!sampleTick && !rdEn)[*2] ##1 rdDiag |=> rdData[15:2] == 14'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared by read");
  property p_stim; wHi && wrData[3:0] == 4'h2 |-> ##[1:4] (stimNeg && !stimPos); endproperty
  a_stim: assert property (p_stim) else $error("negative stimulus not applied");
  property p_stpos; wHi && wrData[3:0] == 4'h4 && !stimPos && !stimNeg |-> ##[1:4] stimPos; endproperty
  a_stpos: assert property (p_stpos) else $error("self-test stimulus missing");
  property p_memgo; wHi && wrData[3] && !flashRdEn |=> flashRdEn && flashAddr == '0; endproperty
  a_memgo: assert property (p_memgo) else $error("memory test did not start");
  property p_memstep;
    flashRdEn && flashAddr != FLASH_AW'(FLASH_DEPTH - 1) |=> flashRdEn && flashAddr == $past(flashAddr) + 1'b1;
  endproperty
  a_memstep: assert property (p_memstep) else $error("flash scan skipped");
  cover property (rdDiag ##1 rdData[5]);
  cover property (flashRdEn && flashAddr == FLASH_AW'(FLASH_DEPTH - 1));
  cover property (stimPos && stimNeg);
endmodule

bind dgs_diag_status dgs_diag_chk #(.FLASH_DEPTH(FLASH_DEPTH), .FLASH_AW(FLASH_AW)) dgs_diag_chk_inst (
  .clk_sys, .srst, .sampleTick, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .stimPos, .stimNeg,
  .flashAddr, .flashRdEn, .supplyHigh, .supplyLow, .alarm1, .alarm2, .overrange);

// ---- testbench/dgs_flash_model.sv ----
module dgs_flash_model #(
  parameter AW = 3
) (
  input  wire          clk_sys,
  input  wire          flashRdEn,
  input  wire [AW-1:0] flashAddr,
  input  wire          badSum,
  output logic [15:0]  flashData = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Words hold addr+1; the last word holds their sum, spoilt on request
  localparam logic [15:0] SUM = (2 ** AW) * (2 ** AW - 1) / 2;
  always @(posedge clk_sys) begin
    if (flashRdEn)
      flashData <= (&flashAddr) ? SUM ^ {15'h0000, badSum} : 16'(flashAddr) + 16'h0001;
    else
      flashData <= ~flashData;
  end
endmodule

// ---- testbench/tb_dgs_diag_status.sv ----
module tb_dgs_diag_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 0, srst = 1, sampleTick = 0, autoTick = 0, badSum = 0;
  logic        wrEn = 0, rdEn = 0, supplyHigh = 0, supplyLow = 0;
  logic        alarm1 = 0, alarm2 = 0, overrange = 0, serialFail = 0, flashUpdFail = 0;
  logic [6:0]  wrAddr = 0, rdAddr = 0;
  logic [7:0]  wrData = 0, miscConfig;
  logic [3:0]  respOk = 0;
  logic [15:0] rdData, flashData;
  logic [2:0]  flashAddr;
  logic        stimPos, stimNeg, flashRdEn;
  int          errors = 0, checks = 0;
  dgs_diag_status #(.ST_SETTLE(2), .FLASH_DEPTH(8), .FLASH_AW(3)) dgs_diag_status_inst (.clk_sys, .srst,
    .sampleTick, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .rdData, .respOk, .stimPos, .stimNeg, .flashAddr,
    .flashRdEn, .flashData, .supplyHigh, .supplyLow, .alarm1, .alarm2, .overrange, .serialFail,
    .flashUpdFail, .miscConfig);
  dgs_flash_model #(.AW(3)) dgs_flash_model_inst (.clk_sys, .flashRdEn, .flashAddr, .badSum, .flashData);
  initial forever #4 clk_sys = ~clk_sys;
  always @(negedge clk_sys) sampleTick <= autoTick & ~sampleTick;
  task finish_test;
    if (errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys) {wrEn, wrAddr, wrData} = {1'b1, a, d};
    @(negedge clk_sys) wrEn = 0;
  endtask
  task rd(input logic [6:0] a);
    @(negedge clk_sys) {rdEn, rdAddr} = {1'b1, a};
    @(negedge clk_sys) rdEn = 0;
    @(negedge clk_sys);
  endtask
  task tick1;
    @(posedge clk_sys) autoTick = 1;
    @(posedge clk_sys) autoTick = 0;
  endtask
  task waitIdle;
    rd(7'h34);
    for (int i = 0; i < 100 && rdData[11:10] !== 2'b00; i++) rd(7'h34);
    chk("busy", {14'h0000, rdData[11:10]}, 16'h0000);
  endtask
  task chkDiag(input logic [15:0] e);
    rd(7'h3C);
    repeat (4) @(negedge clk_sys);
    rd(7'h3C);
    chk("diag", rdData, e);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys) srst = 0;
    rd(7'h34);
    chk("misc", rdData, 16'h0006);
    chk("cfg", {8'h00, miscConfig}, 16'h0006);
    wr(7'h34, 8'hFF);
    rd(7'h34);
    chk("misc", rdData, 16'h00C7);
    chk("cfg", {8'h00, miscConfig}, 16'h00C7);
    rd(7'h00);
    chk("unmapped", rdData, 16'h0000);
    supplyHigh = 1;
    rd(7'h3C);
    chk("diag", rdData, 16'h0002);
    {supplyHigh, supplyLow} = 2'b01;
    rd(7'h3C);
    chk("diag", rdData, 16'h0001);
    supplyLow = 0;
    rd(7'h3C);
    chk("diag", rdData, 16'h0000);
    wr(7'h3D, 8'hFF);
    rd(7'h3C);
    chk("diag", rdData, 16'h0000);
    {alarm2, alarm1, overrange, serialFail, flashUpdFail} = 5'h1F;
    tick1();
    rd(7'h3C);
    chk("diag", rdData, 16'h031C);
    rd(7'h3C);
    chk("diag", rdData, 16'h0000);
    tick1();
    rd(7'h3C);
    chk("diag", rdData, 16'h031C);
    {alarm2, alarm1, overrange, serialFail, flashUpdFail} = 5'h00;
    for (int d = 0; d < 4; d++) begin
      wr(7'h35, 8'(d));
      repeat (4) @(negedge clk_sys);
      chk("stim", {14'h0000, stimNeg, stimPos}, 16'(d));
    end
    wr(7'h35, 8'h00);
    @(posedge clk_sys) autoTick = 1;
    badSum = 1;
    wr(7'h35, 8'h08);
    waitIdle();
    chkDiag(16'h0040);
    badSum = 0;
    wr(7'h35, 8'h08);
    waitIdle();
    chkDiag(16'h0000);
    respOk = 4'h5;
    wr(7'h35, 8'h04);
    waitIdle();
    chkDiag(16'hA020);
    finish_test();
  end
endmodule
